// [rtl/mse_exec.sv]
// Purpose: Executes an instruction subset written over APB.
// Assumes: Pin inputs synchronous to pclk; one transfer at a time.
// Notes:   Every transfer has one wait-free access cycle.
`timescale 1ns/1ps
module mse_exec #(
  parameter int unsigned PORT_W  = 6,
  parameter int unsigned PRESC_W = 8,
  parameter logic [5:0]  ADD_OPC = 6'h07,
  parameter logic [5:0]  AND_OPC = 6'h05
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // I/O port pins
  input  wire logic [PORT_W-1:0] gpio_in,
  output logic      [PORT_W-1:0] gpio_out,
  output logic      [PORT_W-1:0] gpio_oe
);

  // ==========================================================
  // State
  logic [7:0]         w_q;
  logic               c_q, half_carry_q, z_q, skip_q;
  logic [7:0]         file_q [32];
  logic [PORT_W-1:0]  out_q, dir_q, oe_q;
  logic [PRESC_W-1:0] presc_q;
  logic [7:0]         option_q;
  logic [11:0]        last_ins_q;
  logic [31:0]        prdata_q;
  logic               pready_q, pslverr_q;

  // ==========================================================
  // APB phases
  logic       setup, fire, wr_fire, exec, run, file_wr;
  logic [4:0] win;
  assign setup   = psel && !penable;
  assign fire    = psel && penable && pready_q;
  assign wr_fire = fire && pwrite;
  assign exec    = wr_fire && (paddr == mse_pkg::ADDR_INSTR);
  assign run     = exec && !skip_q;
  assign win     = paddr[6:2];
  assign file_wr = wr_fire && paddr[mse_pkg::FILE_WIN_BIT]
                   && (paddr[1:0] == 2'b00);

  // ==========================================================
  // Instruction fields and decode
  logic [11:0] ins;
  logic [4:0]  fsel;
  logic [2:0]  bsel;
  logic        dsel;
  logic [7:0]  kval;
  logic        is_add_w, is_and_file, is_and_lit, is_bit_clear;
  logic        is_bit_set, is_skip_low, is_skip_high, is_load_dir;
  assign ins          = pwdata[11:0];
  assign fsel         = ins[4:0];
  assign bsel         = ins[7:5];
  assign dsel         = ins[5];
  assign kval         = ins[7:0];
  assign is_add_w     = (ins[11:6] == ADD_OPC);
  assign is_and_file  = (ins[11:6] == AND_OPC);
  assign is_and_lit   = (ins[11:8] == mse_pkg::OPC_AND_LIT);
  assign is_bit_clear = (ins[11:8] == mse_pkg::OPC_BIT_CLR);
  assign is_bit_set   = (ins[11:8] == mse_pkg::OPC_BIT_SET);
  assign is_skip_low  = (ins[11:8] == mse_pkg::OPC_SKIP_LO);
  assign is_skip_high = (ins[11:8] == mse_pkg::OPC_SKIP_HI);
  assign is_load_dir  = (ins[11:3] == mse_pkg::LOAD_DIR_HI)
                        && (ins[2:0] == mse_pkg::LOAD_DIR_F);

  // ==========================================================
  // Operand fetch
  logic [7:0] pins8, fval, win_val;
  logic       bit_val;
  assign pins8   = 8'(gpio_in);
  assign fval    = (fsel == mse_pkg::F_PORT) ? pins8 : file_q[fsel];
  assign win_val = (win == mse_pkg::F_PORT) ? pins8 : file_q[win];
  assign bit_val = fval[bsel];

  // ==========================================================
  // ALU
  mse_alu_if #(.W(8)) alu_bus ();

  always_comb begin
    alu_bus.a       = w_q;
    alu_bus.b       = is_and_lit ? kval : fval;
    alu_bus.bit_idx = bsel;
    if (is_add_w) begin
      alu_bus.op = mse_pkg::MSE_ALU_ADD;
    end else if (is_bit_clear) begin
      alu_bus.op = mse_pkg::MSE_ALU_BCLR;
    end else if (is_bit_set) begin
      alu_bus.op = mse_pkg::MSE_ALU_BSET;
    end else begin
      alu_bus.op = mse_pkg::MSE_ALU_AND;
    end
  end

  mse_alu #(.W(8)) u_alu (
    .bus (alu_bus.alu)
  );

  logic w_we, f_we, z_we, c_we, psa;
  assign w_we = run && (((is_add_w || is_and_file) && !dsel) || is_and_lit);
  assign f_we = run && (((is_add_w || is_and_file) && dsel)
                || is_bit_clear || is_bit_set);
  assign z_we = run && (is_add_w || is_and_file || is_and_lit);
  assign c_we = run && is_add_w;
  assign psa  = option_q[mse_pkg::OPT_PSA];

  // ==========================================================
  // Working register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_q <= mse_pkg::W_RST;
    end else if (w_we) begin
      w_q <= alu_bus.y;
    end else if (wr_fire && paddr == mse_pkg::ADDR_WREG) begin
      w_q <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z_q <= 1'b0;
    end else if (z_we) begin
      z_q <= alu_bus.zero;
    end else if (wr_fire && paddr == mse_pkg::ADDR_STATUS) begin
      z_q <= pwdata[mse_pkg::ST_Z];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q          <= 1'b0;
      half_carry_q <= 1'b0;
    end else if (c_we) begin
      c_q          <= alu_bus.carry;
      half_carry_q <= alu_bus.half_carry;
    end else if (wr_fire && paddr == mse_pkg::ADDR_STATUS) begin
      c_q          <= pwdata[mse_pkg::ST_C];
      half_carry_q <= pwdata[mse_pkg::ST_HC];
    end
  end

  // Next instruction becomes a no-operation while set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
    end else if (run && is_skip_low && !bit_val) begin
      skip_q <= 1'b1;
    end else if (run && is_skip_high && bit_val) begin
      skip_q <= 1'b1;
    end else if (exec) begin
      skip_q <= 1'b0;
    end
  end

  // ==========================================================
  // File registers and port latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        file_q[i] <= mse_pkg::FILE_RST;
      end
    end else if (f_we && fsel != mse_pkg::F_PORT) begin
      file_q[fsel] <= alu_bus.y;
    end else if (file_wr && win != mse_pkg::F_PORT) begin
      file_q[win] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= mse_pkg::OUT_RST[PORT_W-1:0];
    end else if (f_we && fsel == mse_pkg::F_PORT) begin
      out_q <= alu_bus.y[PORT_W-1:0];
    end else if (file_wr && win == mse_pkg::F_PORT) begin
      out_q <= pwdata[PORT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= mse_pkg::DIR_RST[PORT_W-1:0];
      oe_q  <= ~mse_pkg::DIR_RST[PORT_W-1:0];
    end else if (run && is_load_dir) begin
      dir_q <= w_q[PORT_W-1:0];
      oe_q  <= ~w_q[PORT_W-1:0];
    end
  end

  // ==========================================================
  // Prescaler and option
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
    end else if (f_we && fsel == mse_pkg::F_TIMER && psa) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_q <= mse_pkg::OPTION_RST;
    end else if (wr_fire && paddr == mse_pkg::ADDR_OPTION) begin
      option_q <= {7'h00, pwdata[mse_pkg::OPT_PSA]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ins_q <= 12'h000;
    end else if (exec) begin
      last_ins_q <= ins;
    end
  end

  // ==========================================================
  // APB read path and answer
  logic [31:0] rd_d;
  logic        err_d;

  always_comb begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      err_d = 1'b1;
    end else if (paddr[mse_pkg::FILE_WIN_BIT]) begin
      rd_d = {24'h000000, win_val};
    end else begin
      case (paddr)
        mse_pkg::ADDR_INSTR:  rd_d = {20'h00000, last_ins_q};
        mse_pkg::ADDR_WREG:   rd_d = {24'h000000, w_q};
        mse_pkg::ADDR_STATUS: rd_d = {28'h0000000, skip_q, z_q,
                                      half_carry_q, c_q};
        mse_pkg::ADDR_OPTION: rd_d = {24'h000000, option_q};
        mse_pkg::ADDR_PORT:   rd_d = {8'h00, 8'(dir_q), 8'(out_q), pins8};
        mse_pkg::ADDR_PRESC:  rd_d = 32'(presc_q);
        default:              err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q  <= rd_d;
        pslverr_q <= err_d;
      end
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign gpio_out = out_q;
  assign gpio_oe  = oe_q;

  // ==========================================================
  // Assertions
  logic [8:0] add_ref;
  logic [4:0] nib_ref;
  assign add_ref = {1'b0, w_q} + {1'b0, fval};
  assign nib_ref = {1'b0, w_q[3:0]} + {1'b0, fval[3:0]};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_skip_low;
    run && is_skip_low && !bit_val;
  endsequence
  sequence s_discard;
    skip_q && exec;
  endsequence

  a_port_pins: assert property (run && is_and_file && dsel
      && fsel == mse_pkg::F_PORT
      |=> gpio_out == $past(w_q[PORT_W-1:0] & gpio_in))
    else $error("port rewrite did not use pin levels");
  a_dir_load: assert property (run && is_load_dir
      |=> dir_q == $past(w_q[PORT_W-1:0]))
    else $error("direction latches not loaded from W");
  a_oe_dir: assert property (gpio_oe == ~dir_q)
    else $error("output enable disagrees with direction");
  a_presc_clear: assert property (f_we && fsel == mse_pkg::F_TIMER
      && psa |=> presc_q == '0)
    else $error("prescaler not cleared on timer write");
  a_add_sum: assert property (run && is_add_w && !dsel
      |=> w_q == $past(add_ref[7:0]) && c_q == $past(add_ref[8]))
    else $error("add result or carry wrong");
  a_add_flags: assert property (run && is_add_w
      |=> half_carry_q == $past(nib_ref[4])
      && z_q == ($past(add_ref[7:0]) == 8'h00))
    else $error("add half carry or zero wrong");
  a_and_file: assert property (run && is_and_file && !dsel
      |=> w_q == $past(w_q & fval) && $stable(c_q) && $stable(half_carry_q))
    else $error("file AND wrong");
  a_and_lit: assert property (run && is_and_lit
      |=> w_q == $past(w_q & kval) && z_q == (w_q == 8'h00))
    else $error("literal AND wrong");
  a_bit_clear: assert property (run && is_bit_clear
      && fsel != mse_pkg::F_PORT
      |=> !file_q[$past(fsel)][$past(bsel)] && $stable({c_q, z_q}))
    else $error("bit clear wrong");
  a_bit_set: assert property (run && is_bit_set
      && fsel != mse_pkg::F_PORT
      |=> file_q[$past(fsel)][$past(bsel)] && $stable({c_q, z_q}))
    else $error("bit set wrong");
  a_skip_low: assert property (s_skip_low
      |=> skip_q ##1 (skip_q || $past(exec)))
    else $error("skip on low bit not armed");
  a_skip_nop: assert property (s_discard
      |=> !skip_q && $stable(w_q) && $stable(dir_q) && $stable(z_q))
    else $error("discarded instruction had an effect");
  a_skip_high: assert property (run && is_skip_high
      |=> skip_q == $past(bit_val) && $stable({c_q, half_carry_q, z_q}))
    else $error("skip on high bit wrong");

endmodule

// [rtl/mse_pkg.sv]
// Purpose: Shared constants and types for the instruction subset executor.
// Assumes: APB slave with 32-bit data, byte addresses below 0x100.
// Notes:   File window occupies 0x80-0xFC, one word per file register.
// Overview of operation
// - Port read-modify-write uses pin levels as source
// - Direction load with file six copies W
// - Direction bit one floats pin; zero drives
// - Timer register write by an instruction clears prescaler when assigned; a file window write does not
// - Add W and file, destination select, flags
// - AND W with file; only zero flag changes
// - AND W with literal into W, zero flag
// - Bit clear forces bit low, flags untouched
// - Bit set forces bit high, flags untouched
// - Skip-if-low discards next instruction when bit zero
// - Skip-if-high discards next instruction when bit one
package mse_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_INSTR  = 8'h00;
  localparam logic [7:0] ADDR_WREG   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_OPTION = 8'h0C;
  localparam logic [7:0] ADDR_PORT   = 8'h10;
  localparam logic [7:0] ADDR_PRESC  = 8'h14;
  localparam int         FILE_WIN_BIT = 7;

  // ==========================================================
  // Field positions
  localparam int ST_C    = 0;
  localparam int ST_HC   = 1;
  localparam int ST_Z    = 2;
  localparam int ST_SKIP = 3;
  localparam int OPT_PSA = 0;

  // ==========================================================
  // Special file registers and opcodes
  localparam logic [4:0] F_TIMER      = 5'h01;
  localparam logic [4:0] F_PORT       = 5'h06;
  localparam logic [8:0] LOAD_DIR_HI  = 9'h000;
  localparam logic [2:0] LOAD_DIR_F   = 3'h6;
  localparam logic [3:0] OPC_BIT_CLR  = 4'h4;
  localparam logic [3:0] OPC_BIT_SET  = 4'h5;
  localparam logic [3:0] OPC_SKIP_LO  = 4'h6;
  localparam logic [3:0] OPC_SKIP_HI  = 4'h7;
  localparam logic [3:0] OPC_AND_LIT  = 4'hE;

  // ==========================================================
  // Reset values
  localparam logic [7:0] W_RST      = 8'h00;
  localparam logic [7:0] FILE_RST   = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'hFF;
  localparam logic [7:0] OUT_RST    = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'h01;

  typedef enum logic [1:0] {
    MSE_ALU_ADD  = 2'b00,
    MSE_ALU_AND  = 2'b01,
    MSE_ALU_BCLR = 2'b10,
    MSE_ALU_BSET = 2'b11
  } mse_alu_op_t;

endpackage

// [rtl/mse_alu_if.sv]
// Purpose: Carrier between the executor and its ALU.
// Assumes: Combinational ALU.
// Notes:   None.
`timescale 1ns/1ps
interface mse_alu_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0]          a;
  logic [W-1:0]          b;
  mse_pkg::mse_alu_op_t  op;
  logic [$clog2(W)-1:0]  bit_idx;
  logic [W-1:0]          y;
  logic                  carry;
  logic                  half_carry;
  logic                  zero;

  modport core (output a, b, op, bit_idx, input y, carry, half_carry, zero);
  modport alu  (input a, b, op, bit_idx, output y, carry, half_carry, zero);
endinterface

// [rtl/mse_alu.sv]
// Purpose: Arithmetic and bit operations of the instruction subset.
// Assumes: W of at least eight bits.
// Notes:   Half carry is taken from the low nibble.
`timescale 1ns/1ps
module mse_alu #(
  parameter int unsigned W = 8
) (
  // Operands and results
  mse_alu_if.alu bus
);

  logic [W:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum            = {1'b0, bus.a} + {1'b0, bus.b};
    nib            = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
    bus.carry      = 1'b0;
    bus.half_carry = 1'b0;
    case (bus.op)
      mse_pkg::MSE_ALU_ADD: begin
        bus.y          = sum[W-1:0];
        bus.carry      = sum[W];
        bus.half_carry = nib[4];
      end
      mse_pkg::MSE_ALU_AND:  bus.y = bus.a & bus.b;
      mse_pkg::MSE_ALU_BCLR: begin
        bus.y              = bus.b;
        bus.y[bus.bit_idx] = 1'b0;
      end
      mse_pkg::MSE_ALU_BSET: begin
        bus.y              = bus.b;
        bus.y[bus.bit_idx] = 1'b1;
      end
      default: bus.y = bus.b;
    endcase
    bus.zero = (bus.y == '0);
  end

endmodule

// [test/mse_exec_test.sv]
// Purpose: Self-checking bench for the instruction subset executor.
// Assumes: Wait-free APB slave; default opcode parameters.
// Notes:   Expected values are derived here from the instruction set.
`timescale 1ns/1ps
module mse_exec_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  gpio_in;
  logic [5:0]  gpio_out;
  logic [5:0]  gpio_oe;
  int          n_fail;
  int          samples_checked;
  logic [31:0] v;
  logic [31:0] v2;
  logic        err;

  mse_exec #(.PORT_W(6), .PRESC_W(8), .ADD_OPC(6'h07), .AND_OPC(6'h05))
  i_mse_exec (
    .pclk    (pclk),    .presetn (presetn),
    .psel    (psel),    .penable (penable),
    .pwrite  (pwrite),  .paddr   (paddr),
    .pwdata  (pwdata),  .prdata  (prdata),
    .pready  (pready),  .pslverr (pslverr),
    .gpio_in (gpio_in), .gpio_out(gpio_out),
    .gpio_oe (gpio_oe)
  );

  always #2.5 pclk = ~pclk;

  // ==========================================================
  // Reporting
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================================
  // APB master
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    v   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic ins(input logic [11:0] x);
    wr(mse_pkg::ADDR_INSTR, {20'h0, x});
  endtask

  function automatic logic [7:0] fa(input int f);
    return 8'h80 + 8'(f * 4);
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("gpio_oe", 32'h0, {26'h0, gpio_oe});
    chk("gpio_out", 32'h0, {26'h0, gpio_out});
    rd(8'h40);
    chk("pslverr", 32'h1, {31'h0, err});
    rd(8'h81);
    chk("pslverr_align", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask

  task automatic add_case(input logic [7:0] w, input logic [7:0] f,
                          input logic d);
    logic [8:0] s;
    logic       h;
    s = {1'b0, w} + {1'b0, f};
    h = ({1'b0, w[3:0]} + {1'b0, f[3:0]}) > 5'hF;
    wr(mse_pkg::ADDR_WREG, {24'h0, w});
    wr(fa(2), {24'h0, f});
    ins({6'h07, d, 5'h02});
    rd(d ? fa(2) : mse_pkg::ADDR_WREG);
    chk("add_result", {24'h0, s[7:0]}, {24'h0, v[7:0]});
    rd(d ? mse_pkg::ADDR_WREG : fa(2));
    chk("add_other", {24'h0, d ? w : f}, {24'h0, v[7:0]});
    rd(mse_pkg::ADDR_STATUS);
    chk("add_flags", {29'h0, s[7:0] == 8'h0, h, s[8]}, {29'h0, v[2:0]});
  endtask

  task automatic and_case(input logic [7:0] w, input logic [7:0] f,
                          input logic d);
    wr(mse_pkg::ADDR_WREG, {24'h0, w});
    wr(fa(3), {24'h0, f});
    wr(mse_pkg::ADDR_STATUS, 32'h3);
    ins({6'h05, d, 5'h03});
    rd(d ? fa(3) : mse_pkg::ADDR_WREG);
    chk("and_result", {24'h0, w & f}, {24'h0, v[7:0]});
    rd(mse_pkg::ADDR_STATUS);
    chk("and_flags", {29'h0, (w & f) == 8'h0, 2'b11}, {29'h0, v[2:0]});
  endtask

  task automatic lit_case(input logic [7:0] w, input logic [7:0] k);
    wr(mse_pkg::ADDR_WREG, {24'h0, w});
    ins({4'hE, k});
    rd(mse_pkg::ADDR_WREG);
    chk("and_lit", {24'h0, w & k}, {24'h0, v[7:0]});
    rd(mse_pkg::ADDR_STATUS);
    chk("lit_zero", {31'h0, (w & k) == 8'h0}, {31'h0, v[2]});
  endtask

  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      wr(fa(4), 32'hFF);
      wr(mse_pkg::ADDR_STATUS, 32'h5);
      ins({4'h4, 3'(b), 5'h04});
      rd(fa(4));
      chk("bit_clear", 32'hFF & ~(32'h1 << b), v);
      rd(mse_pkg::ADDR_STATUS);
      chk("clr_flags", 32'h5, {29'h0, v[2:0]});
      wr(fa(4), 32'h0);
      wr(mse_pkg::ADDR_STATUS, 32'h2);
      ins({4'h5, 3'(b), 5'h04});
      rd(fa(4));
      chk("bit_set", 32'h1 << b, v);
      rd(mse_pkg::ADDR_STATUS);
      chk("set_flags", 32'h2, {29'h0, v[2:0]});
    end
    $display("test bits done");
  endtask

  task automatic skip_case(input logic [11:0] x, input logic sk,
                           input logic [7:0] w);
    wr(mse_pkg::ADDR_WREG, {24'h0, w});
    ins(x);
    rd(mse_pkg::ADDR_STATUS);
    chk("skip_flag", {31'h0, sk}, {31'h0, v[3]});
    ins(12'hE0F);
    rd(mse_pkg::ADDR_WREG);
    chk("after_skip", {24'h0, sk ? w : (w & 8'h0F)}, v);
  endtask

  task automatic t_skip();
    wr(fa(5), 32'h01);
    skip_case(12'h625, 1'b1, 8'hF3);
    skip_case(12'h605, 1'b0, 8'hF3);
    skip_case(12'h705, 1'b1, 8'h3C);
    skip_case(12'h725, 1'b0, 8'h3C);
    $display("test skip done");
  endtask

  task automatic t_port();
    wr(fa(6), 32'h3F);
    gpio_in <= 6'h0A;
    ins(12'h506);
    @(posedge pclk);
    #1;
    chk("rmw_latch", 32'h0B, {26'h0, gpio_out});
    wr(mse_pkg::ADDR_WREG, 32'h2A);
    ins(12'h006);
    @(posedge pclk);
    #1;
    chk("dir_load", 32'h15, {26'h0, gpio_oe});
    wr(mse_pkg::ADDR_WREG, 32'h3F);
    ins(12'h005);
    @(posedge pclk);
    #1;
    chk("dir_other_f", 32'h15, {26'h0, gpio_oe});
    ins(12'h166);
    @(posedge pclk);
    #1;
    chk("rmw_and", 32'h0A, {26'h0, gpio_out});
    $display("test port done");
  endtask

  task automatic t_presc();
    rd(mse_pkg::ADDR_OPTION);
    chk("option_rst", 32'h1, v);
    ins(12'h501);
    rd(mse_pkg::ADDR_PRESC);
    chk("presc_clr", 32'h1, {31'h0, v[7:0] < 8'h08});
    wr(mse_pkg::ADDR_OPTION, 32'h0);
    rd(mse_pkg::ADDR_PRESC);
    v2 = v;
    ins(12'h501);
    rd(mse_pkg::ADDR_PRESC);
    chk("presc_run", 32'h1, {31'h0, 8'(v[7:0] - v2[7:0]) >= 8'h03});
    $display("test prescaler done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h0;
    pwdata  = 32'h0;
    gpio_in = 6'h0;
    n_fail  = 0;
    samples_checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    add_case(8'h8F, 8'h71, 1'b0);
    add_case(8'h05, 8'h03, 1'b1);
    add_case(8'hF0, 8'h20, 1'b1);
    $display("test add done");
    and_case(8'hF0, 8'h0F, 1'b1);
    and_case(8'h3C, 8'hF5, 1'b0);
    $display("test and done");
    lit_case(8'hAA, 8'hFF);
    lit_case(8'hAA, 8'h55);
    $display("test literal done");
    t_bits();
    t_skip();
    t_port();
    t_presc();
    conclude();
  end
endmodule
